// File: rtl/cbe_branch_eval.v
// Conditional branch evaluator with an AHB-Lite register slave.
//
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "cbe_defs.vh"

module cbe_branch_eval (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [2:0] hburst,
  input wire [3:0] hprot,
  input wire hmastlock,
  input wire hready,
  input wire [31:0] hwdata,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Result towards the core
  output reg [19:0] next_pc,
  output reg branch_taken,
  output reg result_valid,
  output wire [4:0] flags_out
);

  // One-hot evaluation states.
  localparam ST_IDLE = 3'b001;
  localparam ST_EVAL = 3'b010;
  localparam ST_DONE = 3'b100;

  // Data-phase state of the bus.
  reg dp_write;
  reg dp_read;
  reg [7:0] dp_addr;

  // Register map, one aligned word each:
  //   CMD    kind, operand form, short-direct long flag, tested bit value.
  //   FLAGS  sign, zero, aux carry, overflow/parity and carry flags.
  //   ADDR   address of the branch instruction being evaluated.
  //   DISP   signed relative offset byte.
  //   STATUS done, taken, busy and the instruction length used.
  //   NEXT   address at which the core continues.
  // Unmapped offsets read as zero and ignore writes.
  reg [2:0] cmd_kind;
  reg [2:0] cmd_form;
  reg cmd_long;
  reg cmd_tbit;
  reg [4:0] flag_word_low;
  reg [19:0] instr_addr;
  reg [7:0] relative_offset_byte;
  reg status_done;
  reg status_taken;
  reg [2:0] status_len;

  reg [2:0] state;
  reg [2:0] next_state;

  wire addr_phase;
  wire cmd_write;
  wire cond_taken;
  reg [2:0] instr_len;
  wire [19:0] disp_ext;
  wire [19:0] seq_pc;
  wire [19:0] target_pc;
  reg [31:0] next_hrdata;
  reg rd_fill;

  // The slave never signals an error. Reads take one wait state so that
  // their data can leave a flip-flop; writes complete with none.
  assign hreadyout = ~(dp_read & ~rd_fill);
  assign hresp = 1'b0;

  // Only word transfers are acted upon; narrower ones complete silently.
  // Burst, protection and lock qualifiers are accepted and ignored.
  assign addr_phase = hsel & hready & htrans[1] &
                      (hsize == 3'b010);

  // The data-phase copy only advances when the bus is ready, so a read
  // held by its wait state keeps its address and direction.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_read <= 1'b0;
      dp_addr <= 8'h00;
    end else if (hready) begin
      dp_write <= addr_phase & hwrite;
      dp_read <= addr_phase & ~hwrite;
      dp_addr <= haddr[7:0];
    end
  end

  assign cmd_write = dp_write & (dp_addr == `CBE_OFF_CMD);

  // Register writes in the data phase.
  // Write data stands only in the data phase, hence the registered address.
  // Writes to STATUS and NEXT are dropped, as both are read-only.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_kind <= `CBE_RST_KIND;
      cmd_form <= `CBE_RST_FORM;
      cmd_long <= 1'b0;
      cmd_tbit <= 1'b0;
      flag_word_low <= `CBE_RST_FLAGS;
      instr_addr <= `CBE_RST_ADDR;
      relative_offset_byte <= `CBE_RST_DISP;
    end else if (dp_write) begin
      case (dp_addr)
        `CBE_OFF_CMD: begin
          cmd_kind <= hwdata[`CBE_CMD_KIND_MSB:`CBE_CMD_KIND_LSB];
          cmd_form <= hwdata[`CBE_CMD_FORM_MSB:`CBE_CMD_FORM_LSB];
          cmd_long <= hwdata[`CBE_CMD_LONG_BIT];
          cmd_tbit <= hwdata[`CBE_CMD_TBIT_BIT];
        end
        `CBE_OFF_FLAGS: begin
          flag_word_low <= hwdata[4:0];
        end
        `CBE_OFF_ADDR: begin
          instr_addr <= hwdata[19:0];
        end
        `CBE_OFF_DISP: begin
          relative_offset_byte <= hwdata[7:0];
        end
        default: begin
          cmd_kind <= cmd_kind;
        end
      endcase
    end
  end

  // Flags are only ever written by software, never by an evaluation.
  // Branch forms that modify a flag bit are handled elsewhere in the core.
  assign flags_out = flag_word_low;

  // Condition test against the flag register and the tested bit.
  cbe_cond u_cond (
    .kind(cmd_kind),
    .flags(flag_word_low),
    .test_bit(cmd_tbit),
    .taken(cond_taken)
  );

  // Instruction length by kind and, for the bit test, by operand form.
  // The short direct form has two encodings; the long flag in the command
  // picks the five-byte one over the four-byte one.
  always @* begin
    instr_len = `CBE_LEN_MAG;
    if (cmd_kind == `CBE_K_NEGATIVE) begin
      instr_len = `CBE_LEN_NEG;
    end else if (cmd_kind == `CBE_K_BITCLEAR) begin
      case (cmd_form)
        `CBE_F_REGISTER: instr_len = `CBE_LEN_BIT_SHORT;
        `CBE_F_FLAGLOW: instr_len = `CBE_LEN_BIT_SHORT;
        `CBE_F_FLAGHIGH: instr_len = `CBE_LEN_BIT_SHORT;
        `CBE_F_INDIRECT: instr_len = `CBE_LEN_BIT_SHORT;
        `CBE_F_SFR: instr_len = `CBE_LEN_SFR;
        `CBE_F_SHORTDIR: begin
          instr_len = cmd_long ? `CBE_LEN_SDIR_LONG : `CBE_LEN_SDIR_SHORT;
        end
        `CBE_F_ABS16: instr_len = `CBE_LEN_ABS16;
        `CBE_F_ABS24: instr_len = `CBE_LEN_ABS24;
        default: instr_len = `CBE_LEN_BIT_SHORT;
      endcase
    end
  end

  // Address arithmetic wraps within the 20-bit space.
  // Every upper address bit copies the offset's sign bit, so a negative
  // offset steps backwards from the next instruction.
  genvar gi;
  generate
    for (gi = 8; gi < 20; gi = gi + 1) begin : g_sext
      assign disp_ext[gi] = relative_offset_byte[7];
    end
  endgenerate
  assign disp_ext[7:0] = relative_offset_byte;
  assign seq_pc = instr_addr + {17'h00000, instr_len};
  assign target_pc = seq_pc + disp_ext;

  // A command write launches one evaluation, finished on the second edge after its data phase begins.
  // The command lands at the end of its data phase, the state machine
  // spends one cycle in evaluation with busy set, and the result pulse
  // appears in the cycle after that. A further command write during
  // evaluation restarts it, so the earlier result is never reported.
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (cmd_write) begin
          next_state = ST_EVAL;
        end
      end
      ST_EVAL: begin
        next_state = cmd_write ? ST_EVAL : ST_DONE;
      end
      ST_DONE: begin
        next_state = cmd_write ? ST_EVAL : ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Result capture; a new command write restarts and drops the old result.
  // The next address and the status word hold until the next evaluation;
  // only the valid and taken pulses fall back to zero.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      next_pc <= `CBE_RST_ADDR;
      branch_taken <= 1'b0;
      result_valid <= 1'b0;
      status_done <= 1'b0;
      status_taken <= 1'b0;
      status_len <= 3'h0;
    end else begin
      branch_taken <= 1'b0;
      result_valid <= 1'b0;
      if (state == ST_EVAL && !cmd_write) begin
        result_valid <= 1'b1;
        branch_taken <= cond_taken;
        status_done <= 1'b1;
        status_taken <= cond_taken;
        status_len <= instr_len;
        if (cond_taken) begin
          next_pc <= target_pc;
        end else begin
          next_pc <= seq_pc;
        end
      end else if (cmd_write) begin
        status_done <= 1'b0;
        status_taken <= 1'b0;
      end
    end
  end

  // Read data is a plain mux of registers over the data-phase address.
  // Fields that a register lacks read as zero.
  always @* begin
    next_hrdata = 32'h00000000;
    case (dp_addr)
      `CBE_OFF_CMD: begin
        next_hrdata[`CBE_CMD_KIND_MSB:`CBE_CMD_KIND_LSB] = cmd_kind;
        next_hrdata[`CBE_CMD_FORM_MSB:`CBE_CMD_FORM_LSB] = cmd_form;
        next_hrdata[`CBE_CMD_LONG_BIT] = cmd_long;
        next_hrdata[`CBE_CMD_TBIT_BIT] = cmd_tbit;
      end
      `CBE_OFF_FLAGS: next_hrdata[4:0] = flag_word_low;
      `CBE_OFF_ADDR: next_hrdata[19:0] = instr_addr;
      `CBE_OFF_DISP: next_hrdata[7:0] = relative_offset_byte;
      `CBE_OFF_STATUS: begin
        next_hrdata[`CBE_STAT_DONE_BIT] = status_done;
        next_hrdata[`CBE_STAT_TAKEN_BIT] = status_taken;
        next_hrdata[`CBE_STAT_BUSY_BIT] = (state == ST_EVAL);
        next_hrdata[`CBE_STAT_LEN_MSB:`CBE_STAT_LEN_LSB] = status_len;
      end
      `CBE_OFF_NEXT: next_hrdata[19:0] = next_pc;
      default: next_hrdata = 32'h00000000;
    endcase
  end

  // The word is loaded in the first data-phase cycle of a read and stands
  // in the second, when hreadyout is high; a read straight after a write
  // therefore sees the new value.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_fill <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      rd_fill <= dp_read & ~rd_fill;
      if (dp_read & ~rd_fill) begin
        hrdata <= next_hrdata;
      end else if (hready) begin
        hrdata <= 32'h00000000;
      end
    end
  end

endmodule // cbe_branch_eval

// File: shared/cbe_defs.vh
// Offsets, field positions, reset values and encodings of the branch evaluator.
`ifndef CBE_DEFS_VH
`define CBE_DEFS_VH

// Register byte offsets on the AHB-Lite bus.
`define CBE_OFF_CMD 8'h00
`define CBE_OFF_FLAGS 8'h04
`define CBE_OFF_ADDR 8'h08
`define CBE_OFF_DISP 8'h0C
`define CBE_OFF_STATUS 8'h10
`define CBE_OFF_NEXT 8'h14

// Command register fields.
`define CBE_CMD_KIND_LSB 0
`define CBE_CMD_KIND_MSB 2
`define CBE_CMD_FORM_LSB 4
`define CBE_CMD_FORM_MSB 6
`define CBE_CMD_LONG_BIT 8
`define CBE_CMD_TBIT_BIT 12

// Flag register bit positions.
`define CBE_FLAG_CY 0
`define CBE_FLAG_PV 1
`define CBE_FLAG_AC 2
`define CBE_FLAG_Z 3
`define CBE_FLAG_S 4

// Status register fields.
`define CBE_STAT_DONE_BIT 0
`define CBE_STAT_TAKEN_BIT 1
`define CBE_STAT_BUSY_BIT 2
`define CBE_STAT_LEN_LSB 8
`define CBE_STAT_LEN_MSB 10

// Reset values.
`define CBE_RST_CMD 13'h0000
`define CBE_RST_KIND 3'h0
`define CBE_RST_FORM 3'h0
`define CBE_RST_FLAGS 5'h00
`define CBE_RST_ADDR 20'h00000
`define CBE_RST_DISP 8'h00

// Branch kinds.
`define CBE_K_NEGATIVE 3'h0
`define CBE_K_SLESS 3'h1
`define CBE_K_SGEQ 3'h2
`define CBE_K_SLEQ 3'h3
`define CBE_K_SGREATER 3'h4
`define CBE_K_UNOTABOVE 3'h5
`define CBE_K_UABOVE 3'h6
`define CBE_K_BITCLEAR 3'h7

// Operand forms of the bit-clear test branch.
`define CBE_F_REGISTER 3'h0
`define CBE_F_FLAGLOW 3'h1
`define CBE_F_FLAGHIGH 3'h2
`define CBE_F_INDIRECT 3'h3
`define CBE_F_SFR 3'h4
`define CBE_F_SHORTDIR 3'h5
`define CBE_F_ABS16 3'h6
`define CBE_F_ABS24 3'h7

// Instruction lengths in bytes.
`define CBE_LEN_NEG 3'h2
`define CBE_LEN_MAG 3'h3
`define CBE_LEN_BIT_SHORT 3'h3
`define CBE_LEN_SFR 3'h4
`define CBE_LEN_SDIR_SHORT 3'h4
`define CBE_LEN_SDIR_LONG 3'h5
`define CBE_LEN_ABS16 3'h6
`define CBE_LEN_ABS24 3'h7

`endif

// File: rtl/cbe_cond.v
// Condition test of the conditional branches against the status flags.
`timescale 1ns/1ps
`include "cbe_defs.vh"

module cbe_cond (
  // Selected branch kind
  input wire [2:0] kind,
  // Status flags and tested bit
  input wire [4:0] flags,
  input wire test_bit,
  // Decision
  output reg taken
);

  wire sign_flag;
  wire zero_flag;
  wire ovf_flag;
  wire carry_flag;
  wire signed_less;

  assign sign_flag = flags[`CBE_FLAG_S];
  assign zero_flag = flags[`CBE_FLAG_Z];
  assign ovf_flag = flags[`CBE_FLAG_PV];
  assign carry_flag = flags[`CBE_FLAG_CY];
  // Overflow corrects the sign, so signed order uses their difference.
  assign signed_less = ovf_flag ^ sign_flag;

  always @* begin
    case (kind)
      `CBE_K_NEGATIVE: taken = sign_flag;
      `CBE_K_SLESS: taken = signed_less;
      `CBE_K_SGEQ: taken = ~signed_less;
      `CBE_K_SLEQ: taken = signed_less | zero_flag;
      `CBE_K_SGREATER: taken = ~(signed_less | zero_flag);
      `CBE_K_UNOTABOVE: taken = zero_flag | carry_flag;
      `CBE_K_UABOVE: taken = ~(zero_flag | carry_flag);
      `CBE_K_BITCLEAR: taken = ~test_bit;
      default: taken = 1'b0;
    endcase
  end

endmodule // cbe_cond

// File: dv/cbe_branch_eval_sva.sv
// Port-level assertion checker for the conditional branch evaluator.
`timescale 1ns/1ps
`include "cbe_defs.vh"
module cbe_branch_eval_sva (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Bus request
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  // Result
  input wire [19:0] next_pc,
  input wire branch_taken,
  input wire result_valid,
  input wire [4:0] flags_out
);
  wire ap = hsel & hready & htrans[1] & (hsize == 3'h2) & hwrite;
  wire cmd_ap = ap & (haddr[7:0] == `CBE_OFF_CMD);
  wire flg_ap = ap & (haddr[7:0] == `CBE_OFF_FLAGS);
  reg dph;
  reg [7:0] doff;
  reg [19:0] addr_q;
  reg [7:0] disp_q;
  reg [12:0] cmd_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph <= 1'b0;
      doff <= 8'h00;
    end else begin
      dph <= ap;
      doff <= haddr[7:0];
    end
  end
  // Shadow copies let the target be judged without seeing inside.
  always @(posedge hclk) begin
    if (dph && doff == `CBE_OFF_ADDR)
      addr_q <= hwdata[19:0];
    if (dph && doff == `CBE_OFF_DISP)
      disp_q <= hwdata[7:0];
    if (dph && doff == `CBE_OFF_CMD)
      cmd_q <= hwdata[12:0];
  end
  wire [2:0] kind = cmd_q[2:0];
  wire lt = flags_out[1] ^ flags_out[4];
  wire [19:0] sdist = next_pc - addr_q;
  wire [19:0] tdist = sdist - {{12{disp_q[7]}}, disp_q};
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_cmd_alone;
    cmd_ap ##1 !cmd_ap;
  endsequence
  property p_result; s_cmd_alone |-> ##2 result_valid; endproperty
  a_result: assert property (p_result) else $error("no result");
  property p_cause; result_valid |-> $past(cmd_ap, 3); endproperty
  a_cause: assert property (p_cause) else $error("stray result");
  property p_pulse; result_valid |=> !result_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("long result");
  property p_flags; $changed(flags_out) |-> $past(flg_ap, 2); endproperty
  a_flags: assert property (p_flags) else $error("flags moved");
  property p_hold; $changed(next_pc) |-> result_valid; endproperty
  a_hold: assert property (p_hold) else $error("pc moved");
  property p_dist;
    result_valid && kind != 3'h7 |->
      (branch_taken ? tdist : sdist) == (kind == 3'h0 ? 20'h2 : 20'h3);
  endproperty
  a_dist: assert property (p_dist) else $error("bad target");
  property p_neg;
    result_valid && kind == 3'h0 |-> branch_taken == flags_out[4];
  endproperty
  a_neg: assert property (p_neg) else $error("bad negative");
  property p_sgt;
    result_valid && kind == 3'h4 |-> branch_taken == !(lt | flags_out[3]);
  endproperty
  a_sgt: assert property (p_sgt) else $error("bad greater");
  property p_bit;
    result_valid && kind == 3'h7 |-> branch_taken == !cmd_q[12];
  endproperty
  a_bit: assert property (p_bit) else $error("bad bit test");
endmodule // cbe_branch_eval_sva
bind cbe_branch_eval cbe_branch_eval_sva u_sva (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata, .next_pc,
  .branch_taken, .result_valid, .flags_out);

// File: dv/testbench.sv
// Self-checking testbench of the conditional branch evaluator.
`timescale 1ns/1ps
`include "cbe_defs.vh"
module testbench;
  reg hclk;
  reg hresetn;
  reg hsel;
  reg [31:0] haddr;
  reg [1:0] htrans;
  reg hwrite;
  reg [31:0] hwdata;
  reg [31:0] rd_q;
  wire hreadyout;
  wire [31:0] hrdata;
  wire [19:0] next_pc;
  wire branch_taken;
  wire result_valid;
  wire [4:0] flags_out;
  integer n_mismatch = 0;
  integer total_checks = 0;
  cbe_branch_eval DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hburst(3'h0), .hprot(4'h0), .hmastlock(1'b0), .hready(hreadyout),
    .hwdata(hwdata), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
    .next_pc(next_pc), .branch_taken(branch_taken),
    .result_valid(result_valid), .flags_out(flags_out));
  // Read data is caught at the data-phase edge, before registers move.
  always @(posedge hclk) rd_q <= hrdata;
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task chk(input [31:0] s, input [31:0] e);
    begin
      total_checks = total_checks + 1;
      if (s !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      #1;
    end
  endtask
  task ev(input [2:0] k, input [2:0] fm, input lg, input b, input [4:0] fl,
    input [19:0] ad, input [7:0] ds);
    reg tk;
    reg [2:0] ln;
    reg [19:0] sq;
    reg [19:0] tg;
    integer i;
    begin
      bus(1'b1, `CBE_OFF_FLAGS, {27'h0, fl});
      bus(1'b1, `CBE_OFF_ADDR, {12'h0, ad});
      bus(1'b1, `CBE_OFF_DISP, {24'h0, ds});
      bus(1'b1, `CBE_OFF_CMD, {19'h0, b, 3'h0, lg, 1'h0, fm, 1'h0, k});
      case (k)
        3'h0: tk = fl[4];
        3'h1: tk = fl[1] ^ fl[4];
        3'h2: tk = ~(fl[1] ^ fl[4]);
        3'h3: tk = (fl[1] ^ fl[4]) | fl[3];
        3'h4: tk = ~((fl[1] ^ fl[4]) | fl[3]);
        3'h5: tk = fl[3] | fl[0];
        3'h6: tk = ~(fl[3] | fl[0]);
        default: tk = ~b;
      endcase
      ln = (k == 3'h0) ? 3'h2 : (k != 3'h7 || fm < 3'h4) ? 3'h3 :
        (fm == 3'h5) ? {2'h2, lg} : fm;
      sq = ad + ln;
      // The target wraps within the 20-bit space, as the core's address does.
      tg = sq + {{12{ds[7]}}, ds};
      i = 0;
      while (result_valid !== 1'b1 && i < 8) begin
        @(posedge hclk);
        #1;
        i = i + 1;
      end
      chk(result_valid, 1);
      chk(branch_taken, tk);
      chk(next_pc, tk ? tg : sq);
      chk(flags_out, fl);
      bus(1'b0, `CBE_OFF_STATUS, 32'h0);
      chk(rd_q[10:8], ln);
      chk(rd_q[1], tk);
    end
  endtask
  task t_regs;
    begin
      bus(1'b0, `CBE_OFF_CMD, 32'h0);
      chk(rd_q, 32'h0);
      bus(1'b1, `CBE_OFF_FLAGS, 32'h15);
      bus(1'b1, 8'h40, 32'h5A);
      bus(1'b0, 8'h40, 32'h0);
      chk(rd_q, 32'h0);
      bus(1'b0, `CBE_OFF_FLAGS, 32'h0);
      chk(rd_q, 32'h15);
    end
  endtask
  task t_flag_kinds;
    integer k;
    integer f;
    begin
      for (k = 0; k < 7; k = k + 1) begin
        for (f = 0; f < 32; f = f + 1) begin
          ev(k[2:0], 3'h0, 1'b0, 1'b0, f[4:0], 20'hFFFF8, {f[4:0], 3'h0});
        end
      end
    end
  endtask
  task t_bit_clear;
    integer m;
    begin
      for (m = 0; m < 32; m = m + 1) begin
        ev(3'h7, m[2:0], m[3], m[4], 5'h1F, 20'h00100, 8'h80);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    #500000;
    n_mismatch = n_mismatch + 1;
    finish_test;
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_flag_kinds;
    t_bit_clear;
    finish_test;
  end
endmodule // testbench
